//--- verilog/sar_adc_control_and_trigger.sv
`timescale 1ns/100ps
`include "sar_ctrl_params.svh"
// Summary of operation
// - power config bit 7 set puts the converter in reduced-bias mode.
// - 8-bit pass takes 11 clocks, 10-bit 13, 12-bit four 13-clock passes outside burst mode.
// - enable bit 7 zero shuts converter down; one makes it active.
// - control bit 6 selects burst operation.
// - done flag bit 5 set per conversion, or per whole burst; software clears.
// - writing busy bit 4 starts conversion only when start source is 000.
// - window flag bit 3 set when result lies inside threshold window.
// - start source: 000 software, 001 timer 0, 01x timer 2, 1xx strobe edge.
// - control register at 0xe8, bit-addressable, resets to zero.
// - burst start launches repeat-count conversions; flags act after last one.
// - in burst, enable bit chooses powered-down or enabled idle between bursts.
module sar_adc_control_and_trigger
  import sar_ctrl_pkg::*;
#(
  parameter int REPEAT_W = 3
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_bit_val,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_timer0_overflow,
  input wire logic i_timer2_overflow,
  input wire logic i_external_convert_strobe,
  input wire logic i_eight_bit_mode,
  input wire logic i_twelve_bit_mode,
  input wire logic [REPEAT_W-1:0] i_repeat_count,
  input wire logic i_sar_clk_tick,
  input wire logic i_result_in_window,
  output logic o_converter_power_on,
  output logic o_low_power_select,
  output logic o_pass_start,
  output logic o_conversion_busy,
  output logic o_conversion_done_pulse
);
  // ****************************************
  // register access
  // ****************************************
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] pwr_reg;
  logic [7:0] pwr_next;
  conv_state_e state_reg;
  conv_state_e state_next;
  logic [5:0] clk_cnt_reg;
  logic [REPEAT_W+1:0] pass_cnt_reg;
  logic done_pulse_reg;

  wire ctrl_sel = (i_sfr_addr == `CONV_CTRL_ADDR);
  wire pwr_sel = (i_sfr_addr == `POWER_CFG_ADDR);
  wire ctrl_byte_wr = i_sfr_wr & ctrl_sel;
  wire ctrl_bit_wr = i_bit_wr & ctrl_sel;
  wire [7:0] bit_mask = 8'h01 << i_bit_sel;
  // whole-byte or single-bit write image
  wire [7:0] ctrl_written = ctrl_byte_wr ? i_sfr_wdata :
    (i_bit_val ? (ctrl_reg | bit_mask) : (ctrl_reg & ~bit_mask));
  wire ctrl_any_wr = ctrl_byte_wr | ctrl_bit_wr;
  wire busy_write = ctrl_any_wr & ctrl_written[`BIT_BUSY];
  // a write that sets enable, source and busy together starts at once
  wire [7:0] ctrl_view = ctrl_any_wr ? ctrl_written : ctrl_reg;
  wire enable_bit = ctrl_view[`BIT_ENABLE];
  wire burst_bit = ctrl_view[`BIT_BURST];
  wire [2:0] src_sel = ctrl_view[`SRC_HI:`SRC_LO];
  wire enable_reg_bit = ctrl_reg[`BIT_ENABLE];

  // ****************************************
  // start selection
  // ****************************************
  logic strobe_level;
  logic strobe_rise;
  edge_sync u_strobe_sync
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_external_convert_strobe),
    .o_level(strobe_level),
    .o_rise(strobe_rise)
  );
  wire src_sw = (src_sel == `SRC_SOFTWARE);
  wire src_t0 = (src_sel == `SRC_TIMER0);
  wire src_t2 = (src_sel == `SRC_TIMER2_A) | (src_sel == `SRC_TIMER2_B);
  wire src_pin = src_sel[`SRC_HI];
  wire start_event = (src_sw & busy_write)
    | (src_t0 & i_timer0_overflow)
    | (src_t2 & i_timer2_overflow)
    | (src_pin & strobe_rise);
  // burst mode wakes the converter itself; otherwise enable is required
  wire start_ok = start_event & (state_reg == ST_IDLE) & (enable_bit | burst_bit);

  // ****************************************
  // conversion sequencing
  // ****************************************
  wire [5:0] pass_clks = i_eight_bit_mode ? `CLKS_8BIT : `CLKS_10BIT;
  wire [REPEAT_W+1:0] reps = (i_repeat_count == '0) ?
    (REPEAT_W+2)'(`BURST_DEFAULT) : (REPEAT_W+2)'(i_repeat_count);
  wire [REPEAT_W+1:0] twelve_mult = i_twelve_bit_mode ? (REPEAT_W+2)'(`PASSES_12BIT)
    : (REPEAT_W+2)'(`BURST_DEFAULT);
  // burst runs the repeat count; single mode runs one result (four passes at 12-bit)
  wire [REPEAT_W+1:0] total_passes = burst_bit ? reps : twelve_mult;
  wire pass_end = (state_reg == ST_CONV) & i_sar_clk_tick & (clk_cnt_reg == pass_clks - 6'h01);
  wire last_pass = (pass_cnt_reg == total_passes - (REPEAT_W+2)'(1));
  wire all_done = pass_end & last_pass;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_ok) state_next = ST_CONV;
      ST_CONV: if (pass_end) state_next = last_pass ? ST_IDLE : ST_NEXT;
      ST_NEXT: state_next = ST_CONV;
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (ctrl_any_wr)
      ctrl_next = ctrl_written;
    ctrl_next[`BIT_BUSY] = (state_next != ST_IDLE);
    if (all_done)
    begin
      ctrl_next[`BIT_DONE] = 1'b1;
      if (i_result_in_window)
        ctrl_next[`BIT_WINDOW] = 1'b1;
    end
  end
  assign pwr_next = (i_sfr_wr & pwr_sel) ? i_sfr_wdata : pwr_reg;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_reg <= `CONV_CTRL_RESET;
      pwr_reg <= `POWER_CFG_RESET;
      state_reg <= ST_IDLE;
      clk_cnt_reg <= '0;
      pass_cnt_reg <= '0;
      done_pulse_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pwr_reg <= pwr_next;
      state_reg <= state_next;
      done_pulse_reg <= all_done;
      if (state_reg != ST_CONV)
        clk_cnt_reg <= '0;
      else if (i_sar_clk_tick)
        clk_cnt_reg <= pass_end ? 6'h00 : clk_cnt_reg + 6'h01;
      if (start_ok)
        pass_cnt_reg <= '0;
      else if (pass_end)
        pass_cnt_reg <= pass_cnt_reg + (REPEAT_W+2)'(1);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_sfr_rdata = ctrl_sel ? ctrl_reg : (pwr_sel ? pwr_reg : 8'h00);
  assign o_low_power_select = pwr_reg[`BIT_LOW_POWER];
  assign o_converter_power_on = enable_reg_bit | (state_reg != ST_IDLE);
  assign o_pass_start = (state_reg == ST_IDLE) ? start_ok : (state_reg == ST_NEXT);
  assign o_conversion_busy = ctrl_reg[`BIT_BUSY];
  assign o_conversion_done_pulse = done_pulse_reg;

  // ****************************************
  // checks
  // ****************************************
  a_sw_start_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == ST_IDLE && busy_write && !src_sw && !i_timer0_overflow
     && !i_timer2_overflow && !strobe_rise) |=> state_reg == ST_IDLE)
    else $error("busy write started conversion with hardware source");
  a_sw_start_go: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == ST_IDLE && busy_write && src_sw && enable_bit) |=> o_conversion_busy)
    else $error("software start ignored");
  a_done_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
    all_done |=> ctrl_reg[`BIT_DONE] && done_pulse_reg)
    else $error("done flag not set at end");
  a_window_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (all_done && i_result_in_window) |=> ctrl_reg[`BIT_WINDOW])
    else $error("window flag not set");
  a_window_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (all_done && !i_result_in_window && !ctrl_reg[`BIT_WINDOW] && !ctrl_any_wr)
    |=> !ctrl_reg[`BIT_WINDOW])
    else $error("window flag set outside window");
  a_no_early_done: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (pass_end && !last_pass && !ctrl_reg[`BIT_DONE] && !ctrl_any_wr)
    |=> !done_pulse_reg && !ctrl_reg[`BIT_DONE])
    else $error("done before burst complete");
  a_low_power_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_sfr_wr && pwr_sel) |=> o_low_power_select == $past(i_sfr_wdata[`BIT_LOW_POWER]))
    else $error("low power select not driven");
  a_disabled_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!enable_reg_bit && state_reg == ST_IDLE) |-> !o_converter_power_on)
    else $error("converter powered while disabled");
  a_burst_powers_down: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (all_done && burst_bit && !enable_bit) |=> !o_converter_power_on)
    else $error("converter left powered after burst");
  a_burst_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (start_event && state_reg == ST_IDLE && !enable_bit && !burst_bit)
    |=> state_reg == ST_IDLE)
    else $error("start accepted with converter disabled");
  a_timer0_go: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == ST_IDLE && src_t0 && i_timer0_overflow && enable_bit && !ctrl_any_wr)
    |=> state_reg == ST_CONV)
    else $error("timer 0 overflow ignored");
  a_pin_go: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == ST_IDLE && src_pin && strobe_rise && enable_bit)
    |=> state_reg == ST_CONV)
    else $error("strobe edge ignored");
  c_burst_done: cover property (@(posedge i_core_clk) burst_bit && all_done);
  c_twelve_done: cover property (@(posedge i_core_clk) i_twelve_bit_mode && !burst_bit && all_done);
  c_single_done: cover property (@(posedge i_core_clk) !burst_bit && all_done);
  c_pin_start: cover property (@(posedge i_core_clk) src_pin && start_ok);
endmodule

//--- include/sar_ctrl_params.svh
`ifndef SAR_CTRL_PARAMS_SVH
`define SAR_CTRL_PARAMS_SVH
// register map
`define CONV_CTRL_ADDR 8'he8
`define CONV_CTRL_RESET 8'h00
`define POWER_CFG_ADDR 8'hc8
`define POWER_CFG_RESET 8'h00
// field positions
`define BIT_ENABLE 7
`define BIT_BURST 6
`define BIT_DONE 5
`define BIT_BUSY 4
`define BIT_WINDOW 3
`define BIT_LOW_POWER 7
// start-source codes
`define SRC_SOFTWARE 3'h0
`define SRC_TIMER0 3'h1
`define SRC_TIMER2_A 3'h2
`define SRC_TIMER2_B 3'h3
// start-source field position
`define SRC_HI 2
`define SRC_LO 0
// conversion clock counts per pass, passes per 12-bit result and default repeat count
`define CLKS_8BIT 6'h0b
`define CLKS_10BIT 6'h0d
`define PASSES_12BIT 3'h4
`define BURST_DEFAULT 3'h1
`endif

//--- include/sar_ctrl_pkg.sv
package sar_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_NEXT = 2'b10
  } conv_state_e;
endpackage

//--- verilog/edge_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser with rising-edge detect: stages two and three both high while the held level is low
module edge_sync
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  assign o_level = lvl_reg;
  assign o_rise = s2_reg & s3_reg & ~lvl_reg;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        lvl_reg <= s3_reg;
    end
  end
endmodule

//--- dv/sar_far_side.sv
`timescale 1ns/100ps
// ****
// timers, strobe pin, sar clock
// ****
module sar_far_side
(
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire logic i_pass_start,
  input wire logic [2:0] i_fire,
  output logic o_tick,
  output logic o_t0,
  output logic o_t2,
  output logic o_pin
);
  localparam int TRACK_CYC = 30;
  logic [1:0] cnt_reg = 2'h0;
  int track_reg = 0;
  always_ff @(posedge i_core_clk)
  begin
    cnt_reg <= (cnt_reg == 2'h0) ? (i_slow ? 2'h2 : 2'h0) : cnt_reg - 2'h1;
  end
  // tracking hold after each pass start: 30 clocks of 50 ns is 1.5 us
  always_ff @(posedge i_core_clk)
  begin
    if (i_pass_start)
      track_reg <= TRACK_CYC;
    else if (track_reg != 0)
      track_reg <= track_reg - 1;
  end
  // slow mode mimics a low sar clock rate, run with low power selected
  assign o_tick = (cnt_reg == 2'h0) && (track_reg == 0);
  assign o_t0 = (i_fire == 3'h1);
  assign o_t2 = (i_fire == 3'h2);
  assign o_pin = (i_fire == 3'h3);
endmodule

//--- dv/test_sar_adc_control_and_trigger.sv
`timescale 1ns/100ps
`include "sar_ctrl_params.svh"
module test_sar_adc_control_and_trigger;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'he8;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic bw = 1'b0;
  logic [2:0] bsel = 3'h0;
  logic bval = 1'b0;
  logic m8 = 1'b0;
  logic m12 = 1'b0;
  logic [2:0] rpt = 3'h0;
  logic win = 1'b0;
  logic slow = 1'b0;
  logic [2:0] fire = 3'h0;
  logic [7:0] rd;
  logic tick, t0, t2, pin, pwr, lp, ps, busy, dn;
  int fail_count = 0;
  int cmp_count = 0;
  sar_adc_control_and_trigger DUT (.i_core_clk(clk), .i_rst(rst), .i_sfr_addr(addr),
    .i_sfr_wdata(wd), .i_sfr_wr(wr), .i_bit_wr(bw), .i_bit_sel(bsel), .i_bit_val(bval),
    .o_sfr_rdata(rd), .i_timer0_overflow(t0), .i_timer2_overflow(t2),
    .i_external_convert_strobe(pin), .i_eight_bit_mode(m8), .i_twelve_bit_mode(m12),
    .i_repeat_count(rpt), .i_sar_clk_tick(tick), .i_result_in_window(win),
    .o_converter_power_on(pwr), .o_low_power_select(lp), .o_pass_start(ps),
    .o_conversion_busy(busy), .o_conversion_done_pulse(dn));
  sar_far_side far (.i_core_clk(clk), .i_slow(slow), .i_pass_start(ps), .i_fire(fire),
    .o_tick(tick),
    .o_t0(t0), .o_t2(t2), .o_pin(pin));
  // ****
  // helpers
  // ****
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk(n, e, rd);
  endtask
  task automatic setbit(input logic [2:0] s, input logic v);
    @(posedge clk);
    addr <= `CONV_CTRL_ADDR;
    bsel <= s;
    bval <= v;
    bw <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
  endtask
  // start one conversion or burst, count passes, ticks and done pulses
  task automatic conv(input logic [7:0] c, input logic [2:0] f, input int p, input int t,
    input logic w);
    integer np;
    integer nt;
    integer nd;
    integer nb;
    np = 0;
    nt = 0;
    nd = 0;
    nb = 0;
    @(posedge clk);
    addr <= `CONV_CTRL_ADDR;
    wd <= c;
    wr <= 1'b1;
    win <= w;
    for (int i = 0; i < 300 && nd == 0; i++)
    begin
      @(negedge clk);
      np += ps;
      nt += busy & tick & ~ps;
      nd += dn;
      nb += busy;
      @(posedge clk);
      wr <= 1'b0;
      if (i == 0)
        fire <= f;
      else if ((i == 1 && f != 3'h3) || i == 5)
        fire <= 3'h0;
    end
    chk("passes", p, np);
    chk("ticks", t, nt);
    chk("done pulses", p != 0, nd);
    chk("busy seen", p != 0, nb != 0);
    peek(`CONV_CTRL_ADDR, (c & 8'hef) | ((p != 0) ? {2'h0, 1'b1, 1'b0, w, 3'h0} : 8'h00),
      "control");
    chk("power", c[7], pwr);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    peek(`CONV_CTRL_ADDR, `CONV_CTRL_RESET, "control reset");
    peek(`POWER_CFG_ADDR, `POWER_CFG_RESET, "power reset");
    peek(8'h55, 8'h00, "unmapped");
    put(`POWER_CFG_ADDR, 8'h80);
    @(negedge clk);
    chk("low power", 1'b1, lp);
    conv(8'h90, 3'h0, 1, 13, 1'b1);
    @(posedge clk);
    m8 <= 1'b1;
    slow <= 1'b1;
    conv(8'h90, 3'h0, 1, 11, 1'b0);
    @(posedge clk);
    m8 <= 1'b0;
    slow <= 1'b0;
    m12 <= 1'b1;
    conv(8'h90, 3'h0, 4, 52, 1'b0);
    @(posedge clk);
    m12 <= 1'b0;
    conv(8'h10, 3'h0, 0, 0, 1'b0);
    conv(8'h91, 3'h0, 0, 0, 1'b0);
    for (int s = 1; s < 8; s++)
      conv(8'h80 | 8'(s), (s == 1) ? 3'h1 : (s < 4) ? 3'h2 : 3'h3, 1, 13, 1'b0);
    conv(8'hd0, 3'h0, 1, 13, 1'b0);
    @(posedge clk);
    rpt <= 3'h3;
    conv(8'h50, 3'h0, 3, 39, 1'b1);
    conv(8'hd0, 3'h0, 3, 39, 1'b0);
    setbit(3'h5, 1'b0);
    peek(`CONV_CTRL_ADDR, 8'hc0, "bit clear");
    setbit(3'h6, 1'b0);
    peek(`CONV_CTRL_ADDR, 8'h80, "burst off");
    tally_and_finish();
  end
  initial
  begin
    #500000;
    fail_count++;
    tally_and_finish();
  end
endmodule
